// >>> include/gpe_regs.svh
// gpe_regs.svh: register offsets, field widths and reset values for ports c, d and e
// assumes: included by bare name; word-aligned wishbone byte addresses
`ifndef GPE_REGS_SVH
`define GPE_REGS_SVH

// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define GPE_IDX_PORT_D_DATA        8'h03
`define GPE_IDX_PORT_E_DATA        8'h08
`define GPE_IDX_PORT_C_PULLUP      8'h0C
`define GPE_IDX_PORT_D_DIRECTION   8'h07
`define GPE_IDX_PORT_D_PULLUP      8'h0D
`define GPE_IDX_PORT_E_DIRECTION   8'h0B
`define GPE_IDX_PERIPH_CTRL        8'h10

// ----------------------------------------
// widths and positions
// ----------------------------------------
`define GPE_C_WIDTH                2
`define GPE_D_WIDTH                7
`define GPE_E_WIDTH                2
`define GPE_D_TIMER_TWO_CH_ZERO    6
`define GPE_D_TIMER_ONE_CH_ONE     5
`define GPE_D_TIMER_ONE_CH_ZERO    4
`define GPE_D_SERIAL_CLOCK         3
`define GPE_D_MOSI                 2
`define GPE_D_MISO                 1
`define GPE_D_SLAVE_SELECT         0
`define GPE_E_RX                   1
`define GPE_E_TX                   0

// periph_ctrl fields
`define GPE_CTRL_SPI_ENABLE        0
`define GPE_CTRL_SPI_MASTER        1
`define GPE_CTRL_UART_ENABLE       2
`define GPE_CTRL_T2C0_ELS          4
`define GPE_CTRL_T1C1_ELS          6
`define GPE_CTRL_T1C0_ELS          8
`define GPE_CTRL_WIDTH             10

// ----------------------------------------
// reset values
// ----------------------------------------
`define GPE_RST_DIRECTION_D        7'h00
`define GPE_RST_DIRECTION_E        2'h0
`define GPE_RST_PULLUP_C           2'h0
`define GPE_RST_PULLUP_D           7'h00
`define GPE_RST_CTRL               10'h000

`endif

// >>> include/gpe_pkg.sv
// gpe_pkg.sv: shared types for the port c/d/e block
// assumes: compiled before all rtl files
package gpe_pkg;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef logic [7:0] gpe_byte_t;
  typedef enum logic {
    GPE_BUS_IDLE,
    GPE_BUS_ACK
  } gpe_bus_state_e;
endpackage

// >>> rtl/gpe_sync.sv
// gpe_sync.sv: two-flop synchroniser for a vector of pin inputs
// assumes: inputs asynchronous to clk_i
`timescale 1ns/1ps
module gpe_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_reg;

  // ----------------------------------------
  // two stages, first read only by second
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    meta_reg <= async_i;
    sync_o   <= meta_reg;
  end
endmodule

// >>> rtl/gpe_pin.sv
// gpe_pin.sv: one pad's drive and pullup decision
// assumes: all inputs synchronous to the caller's clock
`timescale 1ns/1ps
module gpe_pin (
  input  wire logic gp_dir_i,
  input  wire logic gp_data_i,
  input  wire logic gp_pullup_i,
  input  wire logic periph_own_i,
  input  wire logic periph_oe_i,
  input  wire logic periph_out_i,
  output logic      pin_o,
  output logic      pin_oe_o,
  output logic      pullup_o
);
  // ----------------------------------------
  // peripheral ownership overrides direction
  // ----------------------------------------
  always_comb begin
    pin_oe_o = periph_own_i ? periph_oe_i : gp_dir_i;
    pin_o    = periph_own_i ? periph_out_i : gp_data_i;
    pullup_o = gp_pullup_i & ~pin_oe_o; // pullup dropped while driving
  end
endmodule

// >>> rtl/gpe_ports.sv
// gpe_ports.sv: port c pullups, port d and port e with peripheral sharing
// assumes: classic wishbone slave, 32-bit data, one clock, sync active-high reset
`timescale 1ns/1ps
`include "gpe_regs.svh"
module gpe_ports (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [9:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             err_o,
  // port c pullup control
  input  wire logic [1:0]  port_c_direction_i,
  output logic      [1:0]  port_c_pullup_o,
  // port d pads
  input  wire logic [6:0]  port_d_pin_i,
  output logic      [6:0]  port_d_pin_o,
  output logic      [6:0]  port_d_pin_oe_o,
  output logic      [6:0]  port_d_pullup_o,
  // port e pads
  input  wire logic [1:0]  port_e_pin_i,
  output logic      [1:0]  port_e_pin_o,
  output logic      [1:0]  port_e_pin_oe_o,
  // spi side
  input  wire logic        spi_clock_out_i,
  input  wire logic        spi_mosi_out_i,
  input  wire logic        spi_miso_out_i,
  output logic             spi_clock_in_o,
  output logic             spi_mosi_in_o,
  output logic             spi_miso_in_o,
  output logic             spi_slave_select_n_o,
  // timer side
  input  wire logic [2:0]  timer_out_i,
  input  wire logic [2:0]  timer_oe_i,
  output logic      [2:0]  timer_in_o,
  // uart side
  input  wire logic        uart_tx_i,
  output logic             uart_rx_o
);
  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [6:0]                  port_d_data_reg;
  logic [6:0]                  port_d_direction_reg;
  logic [6:0]                  port_d_pullup_reg;
  logic [1:0]                  port_e_data_reg;
  logic [1:0]                  port_e_direction_reg;
  logic [1:0]                  port_c_pullup_reg;
  logic [`GPE_CTRL_WIDTH-1:0]  ctrl_reg;
  gpe_pkg::gpe_bus_state_e     bus_state_reg;
  logic [6:0]                  d_sync;
  logic [1:0]                  e_sync;
  logic [7:0]                  index;
  logic                        wr_go;
  logic                        rd_go;
  logic                        hit;
  gpe_pkg::gpe_byte_t          rd_byte;
  logic                        spi_on;
  logic                        spi_master;
  logic                        uart_on;
  logic [6:0]                  d_own;
  logic [6:0]                  d_poe;
  logic [6:0]                  d_pout;
  logic [1:0]                  e_own;
  logic [1:0]                  e_poe;
  logic [1:0]                  e_pout;
  logic [2:0]                  timer_claim;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // pins pass two flops before any read
  gpe_sync #(.WIDTH(7)) u_sync_d (
    .clk_i   (clk_i),
    .async_i (port_d_pin_i),
    .sync_o  (d_sync)
  );
  gpe_sync #(.WIDTH(2)) u_sync_e (
    .clk_i   (clk_i),
    .async_i (port_e_pin_i),
    .sync_o  (e_sync)
  );

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  assign index = adr_i[9:2];
  // a write lands at the edge that also sees ack, with the request still held;
  // a read is captured at the taking edge so its data stands beside ack
  assign wr_go = cyc_i & stb_i & we_i & sel_i[0] & (bus_state_reg == gpe_pkg::GPE_BUS_ACK);
  assign rd_go = cyc_i & stb_i & (bus_state_reg == gpe_pkg::GPE_BUS_IDLE);

  // address hit check
  // mapped indices answer with ack, all others with err
  always_comb begin
    case (index)
      `GPE_IDX_PORT_D_DATA,
      `GPE_IDX_PORT_E_DATA,
      `GPE_IDX_PORT_C_PULLUP,
      `GPE_IDX_PORT_D_DIRECTION,
      `GPE_IDX_PORT_D_PULLUP,
      `GPE_IDX_PORT_E_DIRECTION,
      `GPE_IDX_PERIPH_CTRL: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // ack/err one cycle after request, then drop
  // the second state keeps a held request from being taken twice
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_state_reg <= gpe_pkg::GPE_BUS_IDLE;
      ack_o         <= 1'b0;
      err_o         <= 1'b0;
    end else begin
      case (bus_state_reg)
        gpe_pkg::GPE_BUS_IDLE: begin
          ack_o <= rd_go & hit;
          err_o <= rd_go & ~hit;
          if (rd_go) begin
            bus_state_reg <= gpe_pkg::GPE_BUS_ACK;
          end
        end
        gpe_pkg::GPE_BUS_ACK: begin
          ack_o         <= 1'b0;
          err_o         <= 1'b0;
          bus_state_reg <= gpe_pkg::GPE_BUS_IDLE;
        end
        default: begin
          ack_o         <= 1'b0;
          err_o         <= 1'b0;
          bus_state_reg <= gpe_pkg::GPE_BUS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // data latches (no reset)
  // ----------------------------------------
  // writes land regardless of direction
  // no reset branch: contents survive a reset
  always_ff @(posedge clk_i) begin
    if (wr_go && index == `GPE_IDX_PORT_D_DATA) begin
      port_d_data_reg <= dat_i[6:0];
    end
    if (wr_go && index == `GPE_IDX_PORT_E_DATA) begin
      port_e_data_reg <= dat_i[1:0];
    end
  end

  // ----------------------------------------
  // direction, pullup and control registers
  // ----------------------------------------
  // reset makes every pin an input
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_d_direction_reg <= `GPE_RST_DIRECTION_D;
      port_e_direction_reg <= `GPE_RST_DIRECTION_E;
    end else if (wr_go && index == `GPE_IDX_PORT_D_DIRECTION) begin
      port_d_direction_reg <= dat_i[6:0];
    end else if (wr_go && index == `GPE_IDX_PORT_E_DIRECTION) begin
      port_e_direction_reg <= dat_i[1:0];
    end
  end

  // pullup enables start disconnected
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_d_pullup_reg <= `GPE_RST_PULLUP_D;
      port_c_pullup_reg <= `GPE_RST_PULLUP_C;
    end else if (wr_go && index == `GPE_IDX_PORT_D_PULLUP) begin
      port_d_pullup_reg <= dat_i[6:0];
    end else if (wr_go && index == `GPE_IDX_PORT_C_PULLUP) begin
      port_c_pullup_reg <= dat_i[1:0];
    end
  end

  // peripheral control; top bits need the second byte lane
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= `GPE_RST_CTRL;
    end else if (wr_go && index == `GPE_IDX_PERIPH_CTRL) begin
      ctrl_reg[7:0] <= dat_i[7:0];
      if (sel_i[1]) begin
        ctrl_reg[`GPE_CTRL_WIDTH-1:8] <= dat_i[`GPE_CTRL_WIDTH-1:8];
      end
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  // direction picks latch or pin; upper bits zero
  always_comb begin
    rd_byte = 8'h00;
    case (index)
      `GPE_IDX_PORT_D_DATA: rd_byte = {1'b0, (port_d_direction_reg & port_d_data_reg)
                                       | (~port_d_direction_reg & d_sync)};
      `GPE_IDX_PORT_E_DATA: rd_byte = {6'h00, (port_e_direction_reg & port_e_data_reg)
                                       | (~port_e_direction_reg & e_sync)};
      `GPE_IDX_PORT_C_PULLUP:    rd_byte = {6'h00, port_c_pullup_reg};
      `GPE_IDX_PORT_D_DIRECTION: rd_byte = {1'b0, port_d_direction_reg};
      `GPE_IDX_PORT_D_PULLUP:    rd_byte = {1'b0, port_d_pullup_reg};
      `GPE_IDX_PORT_E_DIRECTION: rd_byte = {6'h00, port_e_direction_reg};
      `GPE_IDX_PERIPH_CTRL:      rd_byte = ctrl_reg[7:0];
      default:                   rd_byte = 8'h00;
    endcase
  end

  // read data registered with ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (rd_go && !we_i) begin
      // control is the only register wider than a byte
      if (index == `GPE_IDX_PERIPH_CTRL) begin
        dat_o <= {22'h000000, ctrl_reg};
      end else begin
        dat_o <= {24'h000000, rd_byte};
      end
    end
  end

  // ----------------------------------------
  // peripheral ownership
  // ----------------------------------------
  assign spi_on     = ctrl_reg[`GPE_CTRL_SPI_ENABLE];
  assign spi_master = ctrl_reg[`GPE_CTRL_SPI_MASTER];
  assign uart_on    = ctrl_reg[`GPE_CTRL_UART_ENABLE];

  // a timer channel claims its pin when either select bit is set
  assign timer_claim[2] = |ctrl_reg[`GPE_CTRL_T2C0_ELS +: 2];
  assign timer_claim[1] = |ctrl_reg[`GPE_CTRL_T1C1_ELS +: 2];
  assign timer_claim[0] = |ctrl_reg[`GPE_CTRL_T1C0_ELS +: 2];

  // ownership and peripheral drive per port d pin
  always_comb begin
    d_own[6] = timer_claim[2];
    d_own[5] = timer_claim[1];
    d_own[4] = timer_claim[0];
    d_own[3] = spi_on;
    d_own[2] = spi_on;
    d_own[1] = spi_on;
    // slave select belongs to the spi only in slave mode
    d_own[0] = spi_on & ~spi_master;
    // drive enables: timers on request, spi by its role
    d_poe[6:4] = timer_oe_i;
    d_poe[3]   = spi_master; // clock driven only as master
    d_poe[2]   = spi_master; // mosi driven only as master
    d_poe[1]   = ~spi_master; // miso driven only as slave
    d_poe[0]   = 1'b0; // slave select always listens
    // drive values while owned
    d_pout[6:4] = timer_out_i;
    d_pout[3]   = spi_clock_out_i;
    d_pout[2]   = spi_mosi_out_i;
    d_pout[1]   = spi_miso_out_i;
    d_pout[0]   = 1'b0;
    // uart: receive pin listens, transmit pin drives
    e_own     = {uart_on, uart_on};
    e_poe[1]  = 1'b0;
    e_poe[0]  = 1'b1;
    e_pout[1] = 1'b0;
    e_pout[0] = uart_tx_i;
  end

  // ----------------------------------------
  // pad logic
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `GPE_D_WIDTH; gi++) begin : g_d
      gpe_pin u_pin (
        .gp_dir_i     (port_d_direction_reg[gi]),
        .gp_data_i    (port_d_data_reg[gi]),
        .gp_pullup_i  (port_d_pullup_reg[gi]),
        .periph_own_i (d_own[gi]),
        .periph_oe_i  (d_poe[gi]),
        .periph_out_i (d_pout[gi]),
        .pin_o        (port_d_pin_o[gi]),
        .pin_oe_o     (port_d_pin_oe_o[gi]),
        .pullup_o     (port_d_pullup_o[gi])
      );
    end
    // port e has no pullups
    for (gi = 0; gi < `GPE_E_WIDTH; gi++) begin : g_e
      gpe_pin u_pin (
        .gp_dir_i     (port_e_direction_reg[gi]),
        .gp_data_i    (port_e_data_reg[gi]),
        .gp_pullup_i  (1'b0),
        .periph_own_i (e_own[gi]),
        .periph_oe_i  (e_poe[gi]),
        .periph_out_i (e_pout[gi]),
        .pin_o        (port_e_pin_o[gi]),
        .pin_oe_o     (port_e_pin_oe_o[gi]),
        .pullup_o     ()
      );
    end
  endgenerate

  // port c pullup gated by its direction
  assign port_c_pullup_o = port_c_pullup_reg & ~port_c_direction_i;

  // ----------------------------------------
  // inputs to peripherals
  // ----------------------------------------
  assign spi_clock_in_o       = d_sync[`GPE_D_SERIAL_CLOCK];
  assign spi_mosi_in_o        = d_sync[`GPE_D_MOSI];
  assign spi_miso_in_o        = d_sync[`GPE_D_MISO];
  // unowned select and receive idle high
  assign spi_slave_select_n_o = d_own[0] ? d_sync[`GPE_D_SLAVE_SELECT] : 1'b1;
  assign timer_in_o           = d_sync[6:4];
  assign uart_rx_o            = uart_on ? e_sync[`GPE_E_RX] : 1'b1;
endmodule

// >>> verif/gpe_pad_model.sv
// gpe_pad_model.sv: pads and outside circuitry of one port
// assumes: design drives oe/out/pullup, bench drives the outside levels
`timescale 1ns/1ps
module gpe_pad_model #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic [W-1:0] oe_i,
  input  wire logic [W-1:0] out_i,
  input  wire logic [W-1:0] pull_i,
  input  wire logic [W-1:0] ext_en_i,
  input  wire logic [W-1:0] ext_val_i,
  output logic      [W-1:0] level_o
);
  // ----
  // pad resolution
  // ----
  logic [W-1:0] float_reg = '0;
  // released lines wander so a stale level never looks valid
  always @(posedge clk_i) begin
    float_reg <= ~float_reg;
  end
  // device drive wins, then outside drive, then pullup, else wander
  always_comb begin
    level_o = (oe_i & out_i) | (~oe_i & ext_en_i & ext_val_i)
            | (~oe_i & ~ext_en_i & (pull_i | float_reg));
  end
endmodule

// >>> verif/gpe_ports_monitor.sv
// gpe_ports_monitor.sv: assertions on the port c/d/e block
// assumes: bound to gpe_ports, sees its ports only
`timescale 1ns/1ps
module gpe_ports_monitor (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic [9:0]  adr_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        err_o,
  input wire logic [1:0]  port_c_direction_i,
  input wire logic [1:0]  port_c_pullup_o,
  input wire logic [6:0]  port_d_pin_i,
  input wire logic [6:0]  port_d_pin_oe_o,
  input wire logic [6:0]  port_d_pullup_o,
  input wire logic [1:0]  port_e_pin_oe_o,
  input wire logic [2:0]  timer_in_o,
  input wire logic        spi_clock_in_o,
  input wire logic        spi_mosi_in_o,
  input wire logic        spi_miso_in_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----
  // bus handshake
  // ----
  wire mapped = adr_i[9:2] inside {8'h03, 8'h07, 8'h08, 8'h0B, 8'h0C, 8'h0D, 8'h10};
  sequence s_take;
    cyc_i && stb_i && !ack_o && !err_o;
  endsequence
  sequence s_ack_pulse;
    ack_o && !err_o ##1 !ack_o;
  endsequence
  a_mapped_ack: assert property (s_take ##0 mapped |=> s_ack_pulse)
    else $error("mapped request not acked once");
  a_unmapped_err: assert property (s_take ##0 !mapped |=> err_o && !ack_o ##1 !err_o)
    else $error("unmapped request not refused");
  a_ack_has_cause: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  a_upper_zero: assert property (ack_o |-> dat_o[31:10] == 22'h0)
    else $error("upper read bits not zero");
  a_data_hold: assert property (!(cyc_i && stb_i) |=> $stable(dat_o))
    else $error("read data changed without request");
  // ----
  // pins
  // ----
  a_pullup_c_off: assert property ((port_c_pullup_o & port_c_direction_i) == 2'h0)
    else $error("port c pullup on an output");
  a_reset_inputs: assert property ($fell(rst_i) |-> port_d_pin_oe_o == 7'h0 &&
    port_e_pin_oe_o == 2'h0 && port_d_pullup_o == 7'h0 && port_c_pullup_o == 2'h0)
    else $error("pins not inputs after reset");
  a_pin_sync: assert property ({timer_in_o, spi_clock_in_o, spi_mosi_in_o,
    spi_miso_in_o} == $past(port_d_pin_i[6:1], 2))
    else $error("pin levels not two-stage synchronised");
endmodule

// >>> verif/gpe_ports_bench.sv
// gpe_ports_bench.sv: self-checking bench of the port c/d/e block
// assumes: design, pad model and monitor compiled before this file
`timescale 1ns/1ps
`include "gpe_regs.svh"
module gpe_ports_bench;
  localparam logic [7:0] ix_d_dat = `GPE_IDX_PORT_D_DATA;
  localparam logic [7:0] ix_e_dat = `GPE_IDX_PORT_E_DATA;
  localparam logic [7:0] ix_d_dir = `GPE_IDX_PORT_D_DIRECTION;
  localparam logic [7:0] ix_e_dir = `GPE_IDX_PORT_E_DIRECTION;
  localparam logic [7:0] ix_d_pu  = `GPE_IDX_PORT_D_PULLUP;
  localparam logic [7:0] ix_c_pu  = `GPE_IDX_PORT_C_PULLUP;
  localparam logic [7:0] ix_ctl   = `GPE_IDX_PERIPH_CTRL;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o, err_o, uart_rx_o;
  logic spi_clock_in_o, spi_mosi_in_o, spi_miso_in_o, spi_slave_select_n_o;
  logic spi_clock_out_i = 1, spi_mosi_out_i = 1, spi_miso_out_i = 0, uart_tx_i = 1;
  logic [9:0] adr_i = '0;
  logic [3:0] sel_i = '0;
  logic [31:0] dat_i = '0, dat_o, q, ev;
  logic [1:0] port_c_direction_i = '0, port_c_pullup_o, port_e_pin_i, port_e_pin_o;
  logic [1:0] port_e_pin_oe_o, e_en = '0, e_val = '0;
  logic [6:0] port_d_pin_i, port_d_pin_o, port_d_pin_oe_o, port_d_pullup_o;
  logic [6:0] d_en = '0, d_val = '0;
  logic [2:0] timer_out_i = '0, timer_oe_i = 3'h7, timer_in_o;
  logic [6:0] te;
  logic [7:0] idx [5];
  logic [31:0] msk [5];
  int fails = 0, total_checks = 0;
  // ----
  // design and pads
  // ----
  gpe_ports gpe_ports_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .err_o(err_o), .port_c_direction_i(port_c_direction_i),
    .port_c_pullup_o(port_c_pullup_o), .port_d_pin_i(port_d_pin_i),
    .port_d_pin_o(port_d_pin_o), .port_d_pin_oe_o(port_d_pin_oe_o),
    .port_d_pullup_o(port_d_pullup_o), .port_e_pin_i(port_e_pin_i),
    .port_e_pin_o(port_e_pin_o), .port_e_pin_oe_o(port_e_pin_oe_o),
    .spi_clock_out_i(spi_clock_out_i), .spi_mosi_out_i(spi_mosi_out_i),
    .spi_miso_out_i(spi_miso_out_i), .spi_clock_in_o(spi_clock_in_o),
    .spi_mosi_in_o(spi_mosi_in_o), .spi_miso_in_o(spi_miso_in_o),
    .spi_slave_select_n_o(spi_slave_select_n_o), .timer_out_i(timer_out_i),
    .timer_oe_i(timer_oe_i), .timer_in_o(timer_in_o), .uart_tx_i(uart_tx_i),
    .uart_rx_o(uart_rx_o));
  gpe_pad_model #(.W(7)) gpe_pad_model_inst (.clk_i(clk_i), .oe_i(port_d_pin_oe_o),
    .out_i(port_d_pin_o), .pull_i(port_d_pullup_o), .ext_en_i(d_en), .ext_val_i(d_val),
    .level_o(port_d_pin_i));
  gpe_pad_model #(.W(2)) gpe_pad_model_e_inst (.clk_i(clk_i), .oe_i(port_e_pin_oe_o),
    .out_i(port_e_pin_o), .pull_i(2'h0), .ext_en_i(e_en), .ext_val_i(e_val),
    .level_o(port_e_pin_i));
  // 250 MHz clock
  always #2 clk_i = ~clk_i;
  // ----
  // tasks
  // ----
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // one classic cycle, held until ack or err is sampled
  task automatic wb(input logic w, input logic [7:0] i, input logic [31:0] d);
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i <= w;
    adr_i <= {i, 2'h0};
    sel_i <= 4'hF;
    dat_i <= d;
    // no own limit: the watchdog ends a wait that never answers
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'h1 && err_o !== 1'h1);
    q = dat_o;
    ev = {31'h0, err_o};
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    wb(1'h1, i, d);
  endtask
  task automatic rd(input logic [7:0] i, input logic [31:0] e, input string n);
    wb(1'h0, i, 32'h0);
    chk(n, e, q);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    #20000;
    fails++;
    summarize();
  end
  // ----
  // tests
  // ----
  initial begin
    idx = '{ix_d_dir, ix_e_dir, ix_c_pu, ix_d_pu, ix_ctl};
    msk = '{32'h7F, 32'h3, 32'h3, 32'h7F, 32'h3FF};
    repeat (3) @(posedge clk_i);
    rst_i <= 1'h0;
    foreach (idx[k]) begin
      rd(idx[k], 32'h0, "reset value");
      wr(idx[k], 32'hFFFF_FFFF);
      rd(idx[k], msk[k], "width mask");
      wr(idx[k], 32'h0);
    end
    wb(1'h0, 8'h05, 32'h0);
    chk("unmapped err", 32'h1, ev);
    chk("unmapped data", 32'h0, q);
    wr(ix_d_dat, 32'h55);
    wr(ix_d_dir, 32'h7F);
    chk("d oe", 32'h7F, port_d_pin_oe_o);
    chk("d out", 32'h55, port_d_pin_o);
    rst_i <= 1'h1;
    @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    chk("d oe reset", 32'h0, port_d_pin_oe_o);
    wr(ix_d_dir, 32'h7F);
    rd(ix_d_dat, 32'h55, "latch kept");
    d_en <= 7'h7F;
    d_val <= 7'h2A;
    wr(ix_d_dir, 32'h0F);
    wr(ix_d_dat, 32'h33);
    repeat (3) @(posedge clk_i);
    rd(ix_d_dat, 32'h23, "d mixed read");
    chk("d out pins", 32'h03, port_d_pin_o & port_d_pin_oe_o);
    wr(ix_d_pu, 32'h7F);
    chk("d pullups", 32'h70, port_d_pullup_o);
    d_en <= 7'h0;
    wr(ix_d_dir, 32'h0);
    repeat (3) @(posedge clk_i);
    rd(ix_d_dat, 32'h7F, "d pulled");
    port_c_direction_i <= 2'h1;
    wr(ix_c_pu, 32'h3);
    chk("c pullups", 32'h2, port_c_pullup_o);
    e_en <= 2'h3;
    e_val <= 2'h1;
    wr(ix_e_dat, 32'h2);
    wr(ix_e_dir, 32'h1);
    repeat (3) @(posedge clk_i);
    rd(ix_e_dat, 32'h0, "e read a");
    wr(ix_e_dir, 32'h2);
    repeat (3) @(posedge clk_i);
    rd(ix_e_dat, 32'h3, "e read b");
    chk("e oe", 32'h2, port_e_pin_oe_o);
    wr(ix_ctl, 32'h4);
    chk("e oe uart", 32'h1, port_e_pin_oe_o);
    chk("e tx pin", 32'h1, port_e_pin_o[0]);
    repeat (3) @(posedge clk_i);
    chk("uart rx", 32'h0, uart_rx_o);
    rd(ix_e_dat, 32'h3, "e read uart");
    wr(ix_ctl, 32'h0);
    chk("e oe gpio", 32'h2, port_e_pin_oe_o);
    chk("uart rx off", 32'h1, uart_rx_o);
    d_en <= 7'h03;
    d_val <= 7'h02;
    wr(ix_d_dir, 32'h01);
    wr(ix_ctl, 32'h1);
    chk("spi slave oe", 32'h02, port_d_pin_oe_o);
    chk("miso pin", 32'h0, port_d_pin_o[1]);
    repeat (3) @(posedge clk_i);
    chk("slave select", 32'h0, spi_slave_select_n_o);
    wr(ix_ctl, 32'h3);
    wr(ix_d_dir, 32'h0D);
    chk("spi master oe", 32'h0D, port_d_pin_oe_o);
    chk("spi pins", 32'h0C, port_d_pin_o & 7'h0C);
    chk("select idle", 32'h1, spi_slave_select_n_o);
    repeat (3) @(posedge clk_i);
    rd(ix_d_dat, 32'h73, "d read spi");
    wr(ix_ctl, 32'h0);
    chk("gpio pins", 32'h0, port_d_pin_o & 7'h0C);
    wr(ix_d_dir, 32'h70);
    for (int k = 0; k < 6; k++) begin
      timer_out_i <= ~3'(k);
      timer_oe_i <= (k % 2 == 0) ? 3'h7 : 3'h0;
      wr(ix_ctl, 32'h10 << k);
      te = (k % 2 == 0) ? 7'h00 : (7'h40 >> (k / 2));
      chk("timer oe", 7'h70 & ~te, port_d_pin_oe_o);
      chk("timer out", timer_out_i[2 - k / 2], port_d_pin_o[6 - k / 2]);
    end
    summarize();
  end
endmodule
bind gpe_ports gpe_ports_monitor gpe_ports_monitor_inst (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
  .port_c_direction_i(port_c_direction_i), .port_c_pullup_o(port_c_pullup_o),
  .port_d_pin_i(port_d_pin_i), .port_d_pin_oe_o(port_d_pin_oe_o),
  .port_d_pullup_o(port_d_pullup_o), .port_e_pin_oe_o(port_e_pin_oe_o),
  .timer_in_o(timer_in_o), .spi_clock_in_o(spi_clock_in_o), .spi_mosi_in_o(spi_mosi_in_o),
  .spi_miso_in_o(spi_miso_in_o));
